// ===== pkg/spm_pkg.sv
package spm_pkg;

  // ********************************
  // Register indices (byte address = index * 4)
  // ********************************
  localparam logic [13:0] IDX_CDR   = 14'h3000;  // clock_divider
  localparam logic [13:0] IDX_CCR   = 14'h3001;  // clock_control
  localparam logic [13:0] IDX_DC1   = 14'h3002;  // device_config_1
  localparam logic [13:0] IDX_DC2   = 14'h3003;  // device_config_2
  localparam logic [13:0] IDX_CMD1  = 14'h3004;  // command_1
  localparam logic [13:0] IDX_CMD2  = 14'h3005;  // command_2
  localparam logic [13:0] IDX_ST1   = 14'h3006;  // port_status_1
  localparam logic [13:0] IDX_ST2   = 14'h3007;  // port_status_2
  localparam logic [13:0] IDX_DAT1  = 14'h3008;  // shift_data_1
  localparam logic [13:0] IDX_DAT2  = 14'h3009;  // shift_data_2
  localparam logic [13:0] IDX_ISTAT = 14'h300a;  // Interrupt status
  localparam logic [13:0] IDX_IMASK = 14'h300b;  // Interrupt mask

  // ********************************
  // Field positions
  // ********************************
  localparam int CC_EN    = 0;  // Port enable
  localparam int DC1_CPOL = 0;  // clock_idle_polarity
  localparam int DC1_CPHA = 1;  // clock_sample_phase
  localparam int DC1_CSHI = 2;  // Chip select active high
  localparam int DC1_DLY  = 3;  // Two-bit select-to-data delay
  localparam int DC1_LOOP = 5;  // Internal loopback
  localparam int DC2_CIE  = 0;  // Character interrupt enable
  localparam int CMD2_LEN = 0;  // Five-bit length minus one
  localparam int CMD2_CS  = 5;  // Two-bit slave number
  localparam int CMD2_GO  = 7;  // Start one character
  localparam int IRQ_CHAR = 0;  // Character done event
  localparam int IRQ_FRM  = 1;  // Frame done event

  // ********************************
  // Reset values
  // ********************************
  localparam logic [15:0] RST_DIV = 16'h0001;
  localparam logic [15:0] RST_REG = 16'h0000;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {SPM_IDLE, SPM_LEAD, SPM_SHIFT, SPM_HOLD} spm_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } spm_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } spm_wb_rsp_t;

  typedef struct packed {
    logic       sclk;
    logic       dout;
    logic [3:0] slave_select_lines;
  } spm_pins_t;

endpackage : spm_pkg

// ===== src/spm_top.sv
// How it works
// RULE1 - Master only: drives clock and selects
// RULE2 - Receive and transmit shift simultaneously
// RULE3 - Character length one to thirty-two bits
// RULE4 - Bit clock from programmable divider
// RULE5 - Four chip selects, one per slave
// RULE6 - Frame of 1-4096 chars, select held
// RULE7 - Optional interrupt per completed character
// RULE8 - Select-to-data delay zero to three clocks
// RULE9 - Programmable clock idle and select polarity
// RULE10 - Software selects launch and sample edge
// RULE11 - Loopback feeds transmit into receive
// RULE12 - No DMA; processor moves all data
// RULE13 - Polarity and phase bits pick mode
// RULE14 - Most significant bit first, then readable
`timescale 1ns/100ps
module spm_top (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // Register bus
  input  wire spm_pkg::spm_wb_req_t wb_req,
  output spm_pkg::spm_wb_rsp_t      wb_rsp,
  // Serial pins
  input  wire logic                 ser_din,
  output spm_pkg::spm_pins_t        pins,
  // Interrupt
  output logic                      irq
);
  import spm_pkg::*;

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    spm_state_t  st;     // Engine state
    logic [15:0] div;    // Half period minus one
    logic [15:0] ccr;    // Clock control
    logic [15:0] dc1;    // Mode bits
    logic [15:0] dc2;    // Interrupt enable
    logic [15:0] cmd1;   // Frame length minus one
    logic [15:0] cmd2;   // Last command
    logic [31:0] txd;    // Transmit word
    logic [31:0] rxd;    // Last received character
    logic [31:0] tx_sh;  // Transmit shifter
    logic [31:0] rx_sh;  // Receive shifter
    logic [4:0]  len;    // Char length minus one
    logic [1:0]  csel;   // Slave of this frame
    logic [15:0] dcnt;   // Divider count
    logic [2:0]  hcnt;   // Lead half periods
    logic [4:0]  bits;   // Bits completed
    logic [12:0] chars;  // Characters completed
    logic [1:0]  istat;  // Sticky events
    logic [1:0]  imask;  // Event mask
    logic        ack;    // Bus answer
    logic [31:0] rdat;   // Read data
    logic        irq;    // Interrupt line
    spm_pins_t   pins;   // Serial outputs
  } spm_q_t;

  spm_q_t      q_r;      // Registered state
  spm_q_t      q_nxt;    // Next state
  logic        req;      // New bus request
  logic        wr;       // Write request
  logic [13:0] idx;      // Register index
  logic        tick;     // Half-period strobe
  logic        rin;      // Receive bit source
  logic        go_wr;    // Character start
  logic        lead_e;   // Next edge is leading
  logic        smp;      // Sample this edge
  logic        chr_done; // Character finished
  logic        frm_done; // Frame finished
  logic [1:0]  w1c;      // Event clear mask
  logic [31:0] rd_mux;   // Read selection
  logic [31:0] tx_load;  // Aligned transmit word

  // ********************************
  // Helpers
  // ********************************
  // Byte lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  // Chip select pin levels
  function automatic logic [3:0] cs_pins(input logic on,
                                         input logic [1:0] n,
                                         input logic hi);
    logic [3:0] a;
    a = on ? (4'h1 << n) : 4'h0;
    cs_pins = hi ? a : ~a;
  endfunction : cs_pins

  // ********************************
  // Decode
  // ********************************
  // Ack never stands twice, so a held request is taken once
  assign req    = wb_req.cyc & wb_req.stb & ~q_r.ack;
  assign wr     = req & wb_req.we;
  assign idx    = wb_req.adr[15:2];
  // RULE4 - divider half period
  assign tick   = (q_r.dcnt == q_r.div);
  // RULE11 - loopback source
  assign rin    = q_r.dc1[DC1_LOOP] ? q_r.pins.dout : ser_din;
  assign go_wr  = wr & (idx == IDX_CMD2) & wb_req.sel[0] & wb_req.dat[CMD2_GO]
                  & q_r.ccr[CC_EN];
  // RULE13 - active level from polarity bit
  assign lead_e = ~(q_r.pins.sclk ^ q_r.dc1[DC1_CPOL]);
  // RULE10 - phase picks sample edge
  assign smp    = (q_r.st == SPM_SHIFT) & tick & (lead_e ^ q_r.dc1[DC1_CPHA]);
  assign w1c    = (wr && idx == IDX_ISTAT && wb_req.sel[0]) ? wb_req.dat[1:0] : 2'h0;
  // RULE14 - left align, MSB out first
  assign tx_load = q_r.txd << (~wb_req.dat[4:0]);

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    q_nxt    = q_r;
    chr_done = 1'b0;
    frm_done = 1'b0;
    // Read mux
    case (idx)
      IDX_CDR:   rd_mux = {16'h0, q_r.div};
      IDX_CCR:   rd_mux = {16'h0, q_r.ccr};
      IDX_DC1:   rd_mux = {16'h0, q_r.dc1};
      IDX_DC2:   rd_mux = {16'h0, q_r.dc2};
      IDX_CMD1:  rd_mux = {16'h0, q_r.cmd1};
      IDX_CMD2:  rd_mux = {16'h0, q_r.cmd2};
      IDX_ST1:   rd_mux = {30'h0, q_r.st == SPM_SHIFT || q_r.st == SPM_LEAD,
                           q_r.st != SPM_IDLE};
      IDX_ST2:   rd_mux = {19'h0, q_r.chars};
      // RULE12 - received data read by processor
      IDX_DAT1:  rd_mux = {16'h0, q_r.rxd[15:0]};
      IDX_DAT2:  rd_mux = {16'h0, q_r.rxd[31:16]};
      IDX_ISTAT: rd_mux = {30'h0, q_r.istat};
      IDX_IMASK: rd_mux = {30'h0, q_r.imask};
      default:   rd_mux = 32'h0;
    endcase
    // Bus answer one cycle after request
    q_nxt.ack  = req;
    q_nxt.rdat = (req & ~wb_req.we) ? rd_mux : 32'h0;
    // Register writes
    if (wr) begin
      case (idx)
        IDX_CDR:   q_nxt.div = merge16(q_r.div, wb_req.dat[15:0], wb_req.sel[1:0]);
        IDX_CCR:   q_nxt.ccr = merge16(q_r.ccr, wb_req.dat[15:0], wb_req.sel[1:0]);
        IDX_DC1:   q_nxt.dc1 = merge16(q_r.dc1, wb_req.dat[15:0], wb_req.sel[1:0]);
        IDX_DC2:   q_nxt.dc2 = merge16(q_r.dc2, wb_req.dat[15:0], wb_req.sel[1:0]);
        IDX_CMD1:  q_nxt.cmd1 = merge16(q_r.cmd1, wb_req.dat[15:0], wb_req.sel[1:0]);
        IDX_CMD2:  q_nxt.cmd2 = merge16(q_r.cmd2, wb_req.dat[15:0], wb_req.sel[1:0]);
        // RULE12 - transmit data written by processor
        IDX_DAT1:  q_nxt.txd[15:0] = merge16(q_r.txd[15:0], wb_req.dat[15:0],
                                             wb_req.sel[1:0]);
        IDX_DAT2:  q_nxt.txd[31:16] = merge16(q_r.txd[31:16], wb_req.dat[15:0],
                                              wb_req.sel[1:0]);
        IDX_IMASK: begin
          if (wb_req.sel[0]) begin
            q_nxt.imask = wb_req.dat[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Divider runs only while a character is active
    if ((q_r.st == SPM_LEAD || q_r.st == SPM_SHIFT) && !tick) begin
      q_nxt.dcnt = q_r.dcnt + 16'h1;
    end else begin
      q_nxt.dcnt = 16'h0;
    end
    // Serial engine
    case (q_r.st)
      // Waiting for a command
      SPM_IDLE, SPM_HOLD: begin
        if (go_wr) begin
          q_nxt.st    = SPM_LEAD;
          // RULE3 - latch programmed length
          q_nxt.len   = wb_req.dat[CMD2_LEN +: 5];
          q_nxt.tx_sh = tx_load;
          q_nxt.rx_sh = 32'h0;
          q_nxt.bits  = 5'h0;
          q_nxt.hcnt  = 3'h0;
          q_nxt.pins.dout = tx_load[31];
          if (q_r.st == SPM_IDLE) begin
            // RULE5 - one select per slave
            q_nxt.csel  = wb_req.dat[CMD2_CS +: 2];
            q_nxt.chars = 13'h0;
          end
        end
      end
      // Select asserted, waiting out the delay
      SPM_LEAD: begin
        if (tick) begin
          // RULE8 - twice the delay plus setup half
          if (q_r.hcnt == {q_r.dc1[DC1_DLY +: 2], 1'b0}) begin
            q_nxt.st = SPM_SHIFT;
          end else begin
            q_nxt.hcnt = q_r.hcnt + 3'h1;
          end
        end
      end
      // Clock toggling
      SPM_SHIFT: begin
        if (tick) begin
          // RULE1 - clock generated here
          q_nxt.pins.sclk = ~q_r.pins.sclk;
          // RULE2 - sample and launch in one transfer
          if (smp) begin
            q_nxt.rx_sh = {q_r.rx_sh[30:0], rin};
          end else if (lead_e || q_r.bits != q_r.len) begin
            // RULE14 - next bit leaves from the top
            q_nxt.pins.dout = lead_e ? q_r.tx_sh[31] : q_r.tx_sh[30];
            q_nxt.tx_sh     = {q_r.tx_sh[30:0], 1'b0};
          end
          if (!lead_e) begin
            // RULE3 - stop after exactly len plus one bits
            if (q_r.bits == q_r.len) begin
              chr_done = 1'b1;
            end else begin
              q_nxt.bits = q_r.bits + 5'h1;
            end
          end
        end
        if (chr_done) begin
          q_nxt.rxd   = q_nxt.rx_sh;
          q_nxt.chars = q_r.chars + 13'h1;
          // RULE6 - select held until last char
          if (q_r.chars == {1'b0, q_r.cmd1[11:0]}) begin
            frm_done = 1'b1;
            q_nxt.st = SPM_IDLE;
          end else begin
            q_nxt.st = SPM_HOLD;
          end
        end
      end
      default: begin
        q_nxt.st = SPM_IDLE;
      end
    endcase
    // RULE9 - idle clock level and select polarity
    if (q_nxt.st != SPM_SHIFT) begin
      q_nxt.pins.sclk = q_nxt.dc1[DC1_CPOL];
    end
    q_nxt.pins.slave_select_lines = cs_pins(q_nxt.st != SPM_IDLE, q_nxt.csel,
                                            q_nxt.dc1[DC1_CSHI]);
    // RULE7 - char event only when enabled; set wins
    // Event beats a clear in the same cycle, so none is lost
    q_nxt.istat = (q_r.istat & ~w1c)
                  | {frm_done, chr_done & q_r.dc2[DC2_CIE]};
    q_nxt.irq   = |(q_nxt.istat & q_nxt.imask);
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_r       <= '0;
      q_r.st    <= SPM_IDLE;
      q_r.div   <= RST_DIV;
      q_r.ccr   <= RST_REG;
      q_r.dc1   <= RST_REG;
      q_r.dc2   <= RST_REG;
      q_r.cmd1  <= RST_REG;
      q_r.cmd2  <= RST_REG;
      q_r.pins.slave_select_lines <= 4'hf;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign wb_rsp.ack = q_r.ack;
  assign wb_rsp.dat = q_r.rdat;
  assign pins       = q_r.pins;
  assign irq        = q_r.irq;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // RULE12 - one-cycle answer
  chk_bus_ack: assert property (req |=> q_r.ack ##1 !q_r.ack) // RULE12
    else $error("bus ack not one cycle after request");

  // RULE3 - bit count bounded by length
  chk_char_len: assert property ((q_r.st == SPM_SHIFT) |-> q_r.bits <= q_r.len) // RULE3
    else $error("bit count passed character length");

  // RULE6 - select one-hot during frame
  chk_cs_frame: assert property ((q_r.st != SPM_IDLE) |->  // RULE6
      $onehot(q_r.pins.slave_select_lines ^ {4{~q_r.dc1[DC1_CSHI]}}))
    else $error("select not held during frame");

  // RULE5 - selected line matches slave
  chk_cs_slave: assert property ((q_r.st == SPM_SHIFT) |->  // RULE5
      (q_r.pins.slave_select_lines[q_r.csel] == q_r.dc1[DC1_CSHI]))
    else $error("wrong slave line asserted");

  // RULE9 - clock idles at polarity
  chk_clk_idle: assert property ((q_r.st != SPM_SHIFT) |->  // RULE9
      q_r.pins.sclk == q_r.dc1[DC1_CPOL])
    else $error("serial clock not at idle level");

  // RULE4 - clock moves only on divider strobe
  chk_clk_rate: assert property (($past(q_r.st) == SPM_SHIFT && q_r.st == SPM_SHIFT  // RULE4
      && $changed(q_r.pins.sclk)) |-> $past(tick))
    else $error("clock edge without divider strobe");

  // RULE8 - lead delay length
  chk_lead_dly: assert property ((q_r.st == SPM_LEAD ##1 q_r.st == SPM_SHIFT) |->  // RULE8
      $past(q_r.hcnt) == {q_r.dc1[DC1_DLY +: 2], 1'b0})
    else $error("select-to-data delay wrong");

  // RULE8 - nothing shifts during the delay
  chk_lead_idle: assert property ((q_r.st == SPM_LEAD) |-> q_r.bits == 5'h0)  // RULE8
    else $error("bits counted before delay ended");

  // RULE7 - enabled character raises interrupt
  chk_irq_char: assert property (  // RULE7
      (chr_done && q_r.dc2[DC2_CIE] && q_r.imask[IRQ_CHAR])
      |=> q_r.irq && q_r.istat[IRQ_CHAR])
    else $error("character interrupt missing");

  // RULE7 - disabled character sets no character flag
  chk_irq_off: assert property (  // RULE7
      (chr_done && !q_r.dc2[DC2_CIE] && !q_r.istat[IRQ_CHAR]) |=> !q_r.istat[IRQ_CHAR])
    else $error("character flag set while disabled");

  // RULE7 - level follows unmasked flags
  chk_irq_level: assert property (q_r.irq == |(q_r.istat & q_r.imask))  // RULE7
    else $error("interrupt level disagrees with flags");

  // RULE11 - loopback samples own output
  chk_loop_bit: assert property ((smp && q_r.dc1[DC1_LOOP]) |=>  // RULE11
      q_r.rx_sh[0] == $past(q_r.pins.dout))
    else $error("loopback bit mismatch");

  // RULE10 - data still on sample edges
  chk_dout_hold: assert property (smp |=> $stable(q_r.pins.dout))  // RULE10
    else $error("data moved on a sampling edge");

  // RULE14 - first bit is the top bit
  chk_msb_first: assert property ((q_r.st != SPM_LEAD ##1 q_r.st == SPM_LEAD) |->  // RULE14
      q_r.pins.dout == q_r.tx_sh[31])
    else $error("first bit not most significant");

  // RULE14 - received word published whole
  chk_rx_done: assert property (chr_done |=> q_r.rxd == q_r.rx_sh)  // RULE14
    else $error("received word not published");

  // RULE6 - last character ends the frame
  chk_frame_end: assert property (frm_done |=> q_r.st == SPM_IDLE)  // RULE6
    else $error("frame did not end after last character");

  // Main scenarios
  // Multi-character frame completes
  cov_frame: cover property (frm_done && q_r.chars > 13'h0);
  // Character in mode three
  cov_mode3: cover property (chr_done && q_r.dc1[DC1_CPOL] && q_r.dc1[DC1_CPHA]);
  // Full-width loopback character
  cov_loop:  cover property (chr_done && q_r.dc1[DC1_LOOP] && q_r.len == 5'h1f);
  // Longest select-to-data delay
  cov_dly3:  cover property (q_r.st == SPM_LEAD && q_r.dc1[DC1_DLY +: 2] == 2'h3);
  // Next character started inside a frame
  cov_hold:  cover property (q_r.st == SPM_HOLD && go_wr);

endmodule : spm_top

// ===== verif/spm_slave_model.sv
`timescale 1ns/100ps
// ********************************
// Slave on one select line
// ********************************
module spm_slave_model (
  // Serial pins seen from the slave
  input  wire logic        sclk,
  input  wire logic        sel_on,
  input  wire logic        mosi,
  // Mode and payload from the bench
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [31:0] tx_word,
  input  wire logic [5:0]  nbits,
  // Reply line and captured bits
  output logic             miso,
  output logic [31:0]      rx_word
);
  logic [31:0] sh;  // Outgoing bits, next one on top
  int          n;   // Bits sampled in this character
  logic        sel_d = 1'b0;  // Select seen one update late

  // Last clock edge and select release share a time step
  always @(sel_on) sel_d <= sel_on;

  initial miso = 1'b0;
  initial rx_word = '0;

  // Select asserted: load first character
  always @(posedge sel_on) begin
    sh = tx_word << (6'h20 - nbits);
    n = 0;
    miso = cpha ? ~miso : sh[31];
  end

  // Released line must not keep its last bit
  always @(negedge sel_on) miso = ~miso;

  // edge roles, MSB first, full duplex
  always @(sclk) begin
    if (sel_d === 1'b1) begin
      if ((sclk != cpol) ^ cpha) begin
        // Sampling edge
        rx_word = {rx_word[30:0], mosi};
        n = n + 1;
        if (cpha && n == nbits) begin
          sh = tx_word << (6'h20 - nbits);
          n = 0;
        end
      end else if (cpha) begin
        // Launch on leading edge
        miso = sh[31];
        sh = sh << 1;
      end else begin
        // Launch on trailing edge, reload at character end
        if (n == nbits) begin
          sh = tx_word << (6'h20 - nbits);
          n = 0;
        end else begin
          sh = sh << 1;
        end
        miso = sh[31];
      end
    end
  end
endmodule : spm_slave_model

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
  import spm_pkg::*;
  // ********************************
  // Signals
  // ********************************
  logic        ref_clk   = 1'b0;  // 20 MHz clock
  logic        srst      = 1'b1;  // Synchronous reset
  spm_wb_req_t wb_req    = '0;    // Bus request
  spm_wb_rsp_t wb_rsp;            // Bus answer
  spm_pins_t   pins;              // Serial pins
  logic        irq;               // Interrupt line
  logic        miso;              // Slave reply
  logic [31:0] s_rx;              // Bits the slave saw
  logic [31:0] s_tx      = '0;    // Bits the slave sends
  logic [5:0]  nbits     = 6'h08; // Slave character length
  logic [1:0]  md        = '0;    // Mode: polarity, phase
  logic [1:0]  cs_n      = '0;    // Watched select line
  logic        cs_hi     = 1'b0;  // Select active level
  logic        p_sclk;            // Clock one cycle ago
  logic        p_sel     = 1'b0;  // Select one cycle ago
  int          n_edge    = 0;     // Clock edges in frame
  int          gap       = 0;     // Cycles select to first edge
  int          e_last    = 0;     // Edges of last frame
  int          g_last    = 0;     // Gap of last frame
  int          err_total = 0;
  int          n_tests   = 0;
  logic [5:0]  lens [4]  = '{6'h01, 6'h20, 6'h08, 6'h0d};
  wire         sel_on    = (pins.slave_select_lines[cs_n] === cs_hi);

  always #25 ref_clk = ~ref_clk;

  spm_top dut (.ref_clk(ref_clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
               .ser_din(miso), .pins(pins), .irq(irq));
  spm_slave_model slave (.sclk(pins.sclk), .sel_on(sel_on), .mosi(pins.dout),
                         .cpol(md[1]), .cpha(md[0]), .tx_word(s_tx), .nbits(nbits),
                         .miso(miso), .rx_word(s_rx));

  // Frame monitor: edge count and lead gap; last edge shows as select drops
  always @(posedge ref_clk) begin
    p_sclk <= pins.sclk;
    p_sel  <= sel_on;
    if (sel_on || p_sel) begin
      if (pins.sclk !== p_sclk) n_edge <= n_edge + 1;
      else if (n_edge == 0) gap <= gap + 1;
    end else begin
      if (n_edge != 0) begin
        e_last <= n_edge;
        g_last <= gap;
      end
      n_edge <= 0;
      gap <= 0;
    end
  end

  // ********************************
  // Helpers
  // ********************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(input logic [13:0] idx, input logic we, input logic [15:0] wd,
                    output logic [15:0] rd_v);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h3, dat: {16'h0, wd}};
    do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
    rd_v = wb_rsp.dat[15:0];
    wb_req <= '0;
    @(posedge ref_clk);
  endtask : wb

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [15:0] x;
    wb(idx, 1'b1, d, x);
  endtask : wr

  task automatic rd(input logic [13:0] idx, output logic [15:0] r);
    wb(idx, 1'b0, 16'h0, r);
  endtask : rd

  task automatic wait_char();
    logic [15:0] s;
    do rd(IDX_ST1, s); while (s[1] !== 1'b0);
  endtask : wait_char

  // One character in a one-character frame
  task automatic xfer(input logic [5:0] len, input logic [1:0] cs, input logic [1:0] dl,
                      input logic [15:0] dv, input logic lp, input logic [31:0] d);
    logic [31:0] m;
    logic [15:0] r1, r2;
    m = (len == 6'h20) ? '1 : ((32'h1 << len) - 32'h1);
    cs_n = cs;
    s_tx = ~d;
    nbits = len;
    wr(IDX_CDR, dv);
    wr(IDX_DC1, {10'h0, lp, dl, cs_hi, md[0], md[1]});
    wr(IDX_DAT1, d[15:0]);
    wr(IDX_DAT2, d[31:16]);
    wr(IDX_CMD2, {8'h0, 1'b1, cs, len[4:0] - 5'h01});
    wait_char();
    rd(IDX_DAT1, r1);
    rd(IDX_DAT2, r2);
    check("rx data", {r2, r1} & m, (lp ? d : ~d) & m);
    if (!lp) begin
      check("slave rx", s_rx & m, d & m);
      check("edges", e_last, 2 * len);
    end
    check("sclk idle", pins.sclk, md[1]);
    check("select idle", pins.slave_select_lines, {4{~cs_hi}});
  endtask : xfer

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_regs();
    logic [15:0] r;
    rd(IDX_CDR, r);
    check("div reset", r, RST_DIV);
    rd(IDX_CMD2, r);
    check("cmd2 reset", r, RST_REG);
    wr(IDX_ST1, 16'hffff);
    rd(IDX_ST1, r);
    check("status ro", r, 16'h0000);
    wr(14'h3010, 16'hffff);
    rd(14'h3010, r);
    check("unmapped", r, 16'h0000);
    wr(IDX_CMD1, 16'h0fff);
    rd(IDX_CMD1, r);
    check("frame len", r, 16'h0fff);
    wr(IDX_CMD1, 16'h0000);
    // Go while disabled starts nothing
    wr(IDX_CMD2, 16'h0087);
    rd(IDX_ST1, r);
    check("disabled", {r, pins.slave_select_lines}, 20'h0000f);
    wr(IDX_CCR, 16'h0001);
  endtask : t_regs

  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      md = k[1:0];
      cs_hi = (k == 3);
      xfer(lens[k], k[1:0], 2'h0, 16'h0001, 1'b0, 32'hc3a5_96e1 ^ k);
    end
    cs_hi = 1'b0;
    md = 2'h0;
  endtask : t_modes

  task automatic t_delay();
    int g0;
    g0 = 0;
    for (int k = 0; k < 4; k++) begin
      xfer(6'h04, 2'h1, k[1:0], 16'h0002, 1'b0, 32'h0000_0009);
      if (k == 0) g0 = g_last;
      check("lead gap", g_last, g0 + 2 * k * 3);
    end
    xfer(6'h20, 2'h2, 2'h0, 16'h0000, 1'b1, 32'h1234_5678);
  endtask : t_delay

  task automatic t_frame();
    logic [15:0] r;
    cs_n = 2'h0;
    nbits = 6'h08;
    s_tx = 32'h0000_003c;
    wr(IDX_DC1, 16'h0000);
    wr(IDX_IMASK, 16'h0000);
    wr(IDX_DC2, 16'h0001);
    wr(IDX_CMD1, 16'h0002);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_DAT1, 16'h00a5);
      wr(IDX_CMD2, 16'h0087);
      wait_char();
      rd(IDX_ST2, r);
      if (k == 1) check("chars done", r, 16'h0002);
    end
    rd(IDX_ISTAT, r);
    check("frame edges", e_last, 32'h30);
    check("istat", r, 16'h0003);
    check("irq masked", irq, 1'b0);
    wr(IDX_IMASK, 16'h0001);
    check("irq on", irq, 1'b1);
    wr(IDX_ISTAT, 16'h0003);
    check("irq clear", irq, 1'b0);
    // Character interrupt disabled: only frame event
    wr(IDX_DC2, 16'h0000);
    wr(IDX_CMD1, 16'h0000);
    wr(IDX_IMASK, 16'h0003);
    xfer(6'h08, 2'h0, 2'h0, 16'h0001, 1'b0, 32'h0000_0081);
    rd(IDX_ISTAT, r);
    check("no char irq", {r, 15'h0, irq}, 32'h0002_0001);
    // Character interrupt enabled: both events, line high
    wr(IDX_ISTAT, 16'h0003);
    wr(IDX_DC2, 16'h0001);
    xfer(6'h05, 2'h3, 2'h1, 16'h0000, 1'b0, 32'h0000_0016);
    rd(IDX_ISTAT, r);
    check("char irq", {r, 15'h0, irq}, 32'h0003_0001);
  endtask : t_frame

  // ********************************
  // Run control
  // ********************************
  task automatic close_out();
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_modes();
    t_delay();
    t_frame();
    close_out();
  end

  // Watchdog: tests need well under 20000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
endmodule : tb
